//--- rtl/swp_standby_ctrl.sv
// standby-domain wake, pin hold and slow clock control
// assumes reset is the standby power-on reset; main reset and bus reset come from same-clock logic
// What this block does
// - with or without main supply: wake detection runs, enabled events pull wake_event_out low.
// - wake sources: both rings, keyboard, mouse, key detector, both tachs, wake GPIOs.
// - main-supply wake pins are input-only while main supply is absent.
// - fan control pins come up driven low after main reset or bus reset.
// - gpio_53_tx_alt comes up low after any reset, never a wake input.
// - gpio_43 drops alternate function without main supply, keeps its other settings.
// - IR pins low without main; after main reset low until port activated.
// - LED pins keep standby control and blinking.
// - wake, runtime registers except the gpio_43 alternate bit, key, LED, tach logic keep state over main loss.
// - clock_detect_reg at 0xF0 bit 0, reset only by standby reset.
// - ext_slow_clock_absent 0 means external clock, 1 means grounded.
// - slow logic uses external clock, or internal divider when absent.
// - without external clock, tach, key and blink need main supply.
// - a nominal 32.768 kHz tick drives tach, blink and key logic.
// - register accesses are ignored while main_supply_good is inactive.
// - standby pins keep working while main_supply_good is inactive.
// - inactive main_supply_good disables the IR half-duplex timeout.
// - pins without standby input paths take no part in wake.
// - the wake output pin stays operational on standby supply.
// - standby reset initialises IR, wake registers and wake logic.
`timescale 1ns/1ps
module swp_standby_ctrl import swp_pkg::*; (
  // clock and resets
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   mainPorReset,
  input  wire logic                   busReset,
  // supply and slow clock pins
  input  wire logic                   mainSupplyGood,
  input  wire logic                   slowClockIn,
  // wake input pins
  input  wire logic                   ringIndicateOneN,
  input  wire logic                   ringIndicateTwoN,
  input  wire logic                   kbdSerialData,
  input  wire logic                   mouseSerialData,
  input  wire logic [1:0]             fanTach,
  input  wire logic [GPIO_WAKE_N-1:0] gpioWakeIn,
  // register port
  input  wire swp_reg_req_s           regReq,
  output logic      [7:0]             regRdData,
  output logic                        regAck,
  // wake output, open drain
  output logic                        wakeEventOutO,
  output logic                        wakeEventOutOe,
  // gpio_43 pad
  input  wire logic                   gpio43AltIn,
  output logic                        gpio43O,
  output logic                        gpio43Oe,
  // fan control pads
  output logic      [1:0]             fanCtlO,
  output logic      [1:0]             fanCtlOe,
  // IR transmit pads and serial port side
  input  wire logic                   secondPortTx,
  output logic                        irTransmitOut,
  output logic                        gpio53TxAlt,
  output logic                        irHalfDuplexTimeoutEn,
  // indicator pads
  output logic                        indicatorOne,
  output logic                        indicatorTwo
);

  localparam int unsigned SYNC_N = 7 + GPIO_WAKE_N;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_N-1:0] rawPins;
  logic [SYNC_N-1:0] syncA_reg;
  logic [SYNC_N-1:0] syncB_reg;
  logic [SYNC_N-1:0] syncC_reg;

  assign rawPins = {gpioWakeIn, fanTach, mouseSerialData, kbdSerialData,
                    ringIndicateTwoN, ringIndicateOneN, slowClockIn};

  // two flops before use, third only for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA_reg <= '1;
      syncB_reg <= '1;
      syncC_reg <= '1;
    end else begin
      syncA_reg <= rawPins;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  logic       mainSyncA_reg;
  logic       mainGood_reg;

  // main supply good is a supply detector output, not clocked
  always_ff @(posedge clk) begin
    if (reset) begin
      mainSyncA_reg <= 1'b0;
      mainGood_reg  <= 1'b0;
    end else begin
      mainSyncA_reg <= mainSupplyGood;
      mainGood_reg  <= mainSyncA_reg;
    end
  end

  logic                   slowClkSync;
  logic                   ring1N, ring2N, kbdData, mouseData;
  logic [1:0]             tachNow, tachOld;
  logic [GPIO_WAKE_N-1:0] gpioNow, gpioOld;

  assign slowClkSync = syncB_reg[0];
  assign ring1N      = syncB_reg[1];
  assign ring2N      = syncB_reg[2];
  assign kbdData     = syncB_reg[3];
  assign mouseData   = syncB_reg[4];
  assign tachNow     = syncB_reg[6:5];
  assign tachOld     = syncC_reg[6:5];
  assign gpioNow     = syncB_reg[SYNC_N-1:7];
  assign gpioOld     = syncC_reg[SYNC_N-1:7];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  wakeEnLo_reg, wakeEnHi_reg;
  logic [7:0]  gpio43Ctl_reg;
  logic [3:0]  fanCtl_reg;
  logic [3:0]  ledCtl_reg;
  logic [1:0]  irCtl_reg;
  logic        clkAbsent_reg;
  logic        wrEn, rdEn;
  logic [WAKE_N-1:0] wakeEn, wakeClr, wakeEvt, wakeSts;

  // no decode without main supply, so floating bus pins do nothing
  assign wrEn = regReq.wr && mainGood_reg;
  assign rdEn = regReq.rd && mainGood_reg;
  assign wakeEn = {wakeEnHi_reg[WAKE_N-9:0], wakeEnLo_reg};

  // wake enables, gpio_43 settings and slow clock select: standby reset only
  always_ff @(posedge clk) begin
    if (reset) begin
      wakeEnLo_reg  <= RST_WAKE_EN;
      wakeEnHi_reg  <= RST_WAKE_EN;
      gpio43Ctl_reg <= RST_GPIO43;
      ledCtl_reg    <= RST_LED;
      clkAbsent_reg <= RST_CLK_ABSENT;
    end else begin
      if (wrEn && regReq.addr == OFS_WAKE_EN_LO) begin
        wakeEnLo_reg <= regReq.wdata;
      end
      if (wrEn && regReq.addr == OFS_WAKE_EN_HI) begin
        wakeEnHi_reg <= regReq.wdata;
      end
      if (wrEn && regReq.addr == OFS_GPIO43_CTL) begin
        gpio43Ctl_reg <= regReq.wdata;
      end else if (!mainGood_reg) begin
        gpio43Ctl_reg[G43_ALT] <= 1'b0;
      end
      if (wrEn && regReq.addr == OFS_LED_CTL) begin
        ledCtl_reg <= regReq.wdata[3:0];
      end
      if (wrEn && regReq.addr == OFS_CLOCK_DETECT) begin
        clkAbsent_reg <= regReq.wdata[CLK_ABSENT];
      end
    end
  end

  // fan pins: back to low outputs on main or bus reset
  always_ff @(posedge clk) begin
    if (reset || mainPorReset || busReset) begin
      fanCtl_reg <= RST_FAN;
    end else if (wrEn && regReq.addr == OFS_FAN_CTL) begin
      fanCtl_reg <= regReq.wdata[3:0];
    end
  end

  // IR control: activate cleared by standby and main reset
  always_ff @(posedge clk) begin
    if (reset || mainPorReset) begin
      irCtl_reg <= RST_IR;
    end else if (wrEn && regReq.addr == OFS_IR_CTL) begin
      irCtl_reg <= regReq.wdata[1:0];
    end
  end

  // write-one-to-clear of the wake flags
  always_comb begin
    wakeClr = '0;
    if (wrEn && regReq.addr == OFS_WAKE_STS_LO) begin
      wakeClr[7:0] = regReq.wdata;
    end
    if (wrEn && regReq.addr == OFS_WAKE_STS_HI) begin
      wakeClr[WAKE_N-1:8] = regReq.wdata[WAKE_N-9:0];
    end
  end

  // read data registered, answer one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData <= 8'h00;
      regAck    <= 1'b0;
    end else begin
      regAck <= wrEn || rdEn;
      if (rdEn) begin
        case (regReq.addr)
          OFS_WAKE_STS_LO:  regRdData <= wakeSts[7:0];
          OFS_WAKE_STS_HI:  regRdData <= {1'b0, wakeSts[WAKE_N-1:8]};
          OFS_WAKE_EN_LO:   regRdData <= wakeEnLo_reg;
          OFS_WAKE_EN_HI:   regRdData <= wakeEnHi_reg;
          OFS_GPIO43_CTL:   regRdData <= gpio43Ctl_reg;
          OFS_FAN_CTL:      regRdData <= {4'h0, fanCtl_reg};
          OFS_LED_CTL:      regRdData <= {4'h0, ledCtl_reg};
          OFS_IR_CTL:       regRdData <= {6'h00, irCtl_reg};
          OFS_CLOCK_DETECT: regRdData <= {7'h00, clkAbsent_reg};
          default:          regRdData <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // slow tick and slow-clocked detectors
  // ---------------------------------------------------------------
  logic slowTick;

  swp_slow_tick #(
    .DIV (SLOW_DIV)
  ) u_tick (
    .clk         (clk),
    .reset       (reset),
    .slowClkSync (slowClkSync),
    .extAbsent   (clkAbsent_reg),
    .mainGood    (mainGood_reg),
    .slowTick    (slowTick)
  );

  logic [1:0] tachSeen_reg;
  logic [1:0] tachEvt;
  logic [1:0] tachRise;
  logic [1:0] settleCnt_reg;
  logic       edgeOk;
  logic [2:0] keyLowCnt_reg;
  logic       keyEvt;

  // sync flops reset high, so edges wait until the third flop holds a real pin sample
  always_ff @(posedge clk) begin
    if (reset) begin
      settleCnt_reg <= 2'h0;
    end else if (!edgeOk) begin
      settleCnt_reg <= settleCnt_reg + 2'h1;
    end
  end
  assign edgeOk   = (settleCnt_reg == 2'h3);
  assign tachRise = edgeOk ? (tachNow & ~tachOld) : 2'b00;

  // tach edges are counted only on slow ticks; a rise in the tick cycle is passed on, not lost
  always_ff @(posedge clk) begin
    if (reset) begin
      tachSeen_reg <= 2'b00;
    end else if (slowTick) begin
      tachSeen_reg <= 2'b00;
    end else begin
      tachSeen_reg <= tachSeen_reg | tachRise;
    end
  end
  assign tachEvt = slowTick ? (tachSeen_reg | tachRise) : 2'b00;

  // key detector: keyboard data held low for a run of slow ticks
  always_ff @(posedge clk) begin
    if (reset || kbdData) begin
      keyLowCnt_reg <= 3'h0;
    end else if (slowTick && keyLowCnt_reg != 3'(KEY_LOW_TICKS)) begin
      keyLowCnt_reg <= keyLowCnt_reg + 3'h1;
    end
  end
  assign keyEvt = slowTick && !kbdData && (keyLowCnt_reg == 3'(KEY_LOW_TICKS - 1));

  // ---------------------------------------------------------------
  // wake events and output
  // ---------------------------------------------------------------
  // only pins with standby input paths feed the latch; gpio_53 is not among them
  always_comb begin
    wakeEvt            = '0;
    wakeEvt[SRC_RING1] = !ring1N && syncC_reg[1];
    wakeEvt[SRC_RING2] = !ring2N && syncC_reg[2];
    wakeEvt[SRC_KBD]   = !kbdData && syncC_reg[3];
    wakeEvt[SRC_MOUSE] = !mouseData && syncC_reg[4];
    wakeEvt[SRC_KEY]   = keyEvt;
    wakeEvt[SRC_TACH1:SRC_TACH0] = tachEvt;
    wakeEvt[WAKE_N-1:SRC_GPIO]   = gpioNow ^ gpioOld;
    if (!edgeOk) begin
      wakeEvt = '0;
    end
  end

  swp_wake_latch #(
    .N (WAKE_N)
  ) u_latch (
    .clk    (clk),
    .reset  (reset),
    .event_ (wakeEvt),
    .clear  (wakeClr),
    .status (wakeSts)
  );

  // runs regardless of main supply; pin pulled low while any enabled flag stands
  always_ff @(posedge clk) begin
    if (reset) begin
      wakeEventOutOe <= 1'b0;
    end else begin
      wakeEventOutOe <= |(wakeSts & wakeEn);
    end
  end
  assign wakeEventOutO = 1'b0;

  // ---------------------------------------------------------------
  // pin holds
  // ---------------------------------------------------------------
  logic g43Val;

  // settings other than the alternate bit kept in the register; drive suppressed while main is absent
  always_comb begin
    g43Val = gpio43Ctl_reg[G43_ALT] ? gpio43AltIn : (gpio43Ctl_reg[G43_OUT] ^ gpio43Ctl_reg[G43_INV]);
    gpio43O  = gpio43Ctl_reg[G43_OD] ? 1'b0 : g43Val;
    gpio43Oe = mainGood_reg && gpio43Ctl_reg[G43_DIR]
               && !(gpio43Ctl_reg[G43_OD] && g43Val);
  end

  // fan pins keep their register-set drive and enable even without main, and are never wake sources
  assign fanCtlOe = fanCtl_reg[1:0];
  assign fanCtlO  = fanCtl_reg[3:2];

  // IR pins: low without main or before activation
  always_ff @(posedge clk) begin
    if (reset || mainPorReset || busReset) begin
      gpio53TxAlt   <= 1'b0;
      irTransmitOut <= 1'b0;
    end else begin
      gpio53TxAlt   <= mainGood_reg && irCtl_reg[IR_ACT] && secondPortTx;
      irTransmitOut <= mainGood_reg && irCtl_reg[IR_ACT] && secondPortTx;
    end
  end

  assign irHalfDuplexTimeoutEn = mainGood_reg && irCtl_reg[IR_HDTO];

  // ---------------------------------------------------------------
  // LED blink on slow ticks, kept across main loss
  // ---------------------------------------------------------------
  logic [13:0] blinkCnt_reg;
  logic        blinkPhase_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      blinkCnt_reg   <= 14'h0000;
      blinkPhase_reg <= 1'b0;
    end else if (slowTick) begin
      if (blinkCnt_reg == 14'(BLINK_TICKS - 1)) begin
        blinkCnt_reg   <= 14'h0000;
        blinkPhase_reg <= !blinkPhase_reg;
      end else begin
        blinkCnt_reg <= blinkCnt_reg + 14'h0001;
      end
    end
  end

  // mode decode per indicator, standby-powered
  always_ff @(posedge clk) begin
    if (reset) begin
      indicatorOne <= 1'b0;
      indicatorTwo <= 1'b0;
    end else begin
      case (swp_led_e'(ledCtl_reg[1:0]))
        LED_BLINK: indicatorOne <= blinkPhase_reg;
        LED_ON:    indicatorOne <= 1'b1;
        default:   indicatorOne <= 1'b0;
      endcase
      case (swp_led_e'(ledCtl_reg[3:2]))
        LED_BLINK: indicatorTwo <= blinkPhase_reg;
        LED_ON:    indicatorTwo <= 1'b1;
        default:   indicatorTwo <= 1'b0;
      endcase
    end
  end

  // the blink and indicator logic above sits on the standby reset alone

endmodule

//--- rtl/swp_pkg.sv
// constants, register map and carrier types for the standby wake and power control block
// assumes a single 50 MHz clock and an 8-bit runtime register port from the host bus decoder
package swp_pkg;

  // ---------------------------------------------------------------
  // clock rates and derived counts
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 50000000;
  localparam int unsigned SLOW_CLK_HZ  = 32768;
  // internal slow tick divider, rounded down so the tick is never slower than nominal
  localparam int unsigned SLOW_DIV     = CLK_HZ / SLOW_CLK_HZ;
  localparam int unsigned BLINK_TICKS  = 16384;    // half a blink period in slow ticks
  localparam int unsigned KEY_LOW_TICKS = 4;       // held-low length that counts as the wake key

  // ---------------------------------------------------------------
  // wake source numbering
  // ---------------------------------------------------------------
  localparam int unsigned GPIO_WAKE_N  = 8;        // bit 0 of the group is gpio_43
  localparam int unsigned SRC_RING1    = 0;
  localparam int unsigned SRC_RING2    = 1;
  localparam int unsigned SRC_KBD      = 2;
  localparam int unsigned SRC_MOUSE    = 3;
  localparam int unsigned SRC_KEY      = 4;
  localparam int unsigned SRC_TACH0    = 5;
  localparam int unsigned SRC_TACH1    = 6;
  localparam int unsigned SRC_GPIO     = 7;
  localparam int unsigned WAKE_N       = SRC_GPIO + GPIO_WAKE_N;

  // ---------------------------------------------------------------
  // runtime register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_WAKE_STS_LO = 8'h00;
  localparam logic [7:0] OFS_WAKE_STS_HI = 8'h01;
  localparam logic [7:0] OFS_WAKE_EN_LO  = 8'h02;
  localparam logic [7:0] OFS_WAKE_EN_HI  = 8'h03;
  localparam logic [7:0] OFS_GPIO43_CTL  = 8'h04;
  localparam logic [7:0] OFS_FAN_CTL     = 8'h05;
  localparam logic [7:0] OFS_LED_CTL     = 8'h06;
  localparam logic [7:0] OFS_IR_CTL      = 8'h07;
  localparam logic [7:0] OFS_CLOCK_DETECT = 8'hf0;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned G43_DIR   = 0;   // 1 = output
  localparam int unsigned G43_INV   = 1;
  localparam int unsigned G43_OD    = 2;   // 1 = open drain
  localparam int unsigned G43_ALT   = 3;   // 1 = alternate function
  localparam int unsigned G43_OUT   = 4;
  localparam int unsigned IR_ACT    = 0;   // second serial port activate
  localparam int unsigned IR_HDTO   = 1;   // half-duplex timeout enable
  localparam int unsigned CLK_ABSENT = 0;  // ext_slow_clock_absent

  localparam logic [7:0] RST_WAKE_EN  = 8'h00;
  localparam logic [7:0] RST_GPIO43   = 8'h00;
  localparam logic [3:0] RST_FAN      = 4'h3;  // both pins output, both low
  localparam logic [3:0] RST_LED      = 4'h0;
  localparam logic [1:0] RST_IR       = 2'h0;
  localparam logic       RST_CLK_ABSENT = 1'b0;

  // led modes
  typedef enum logic [1:0] {LED_OFF, LED_BLINK, LED_ON, LED_OFF2} swp_led_e;

  // register request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } swp_reg_req_s;

endpackage

//--- rtl/swp_slow_tick.sv
// slow clock tick source: external slow clock edges or an internal divider
// assumes the external slow clock arrives already through a two-flop synchroniser
`timescale 1ns/1ps
module swp_slow_tick import swp_pkg::*; #(
  parameter int unsigned DIV = SLOW_DIV
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // controls
  input  wire logic slowClkSync,
  input  wire logic extAbsent,
  input  wire logic mainGood,
  // tick out
  output logic      slowTick
);

  logic        slowClkDly_reg;
  logic [15:0] divCnt_reg;
  logic        intTick;

  // ---------------------------------------------------------------
  // edge detect on the synchronised external clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      slowClkDly_reg <= 1'b0;
    end else begin
      slowClkDly_reg <= slowClkSync;
    end
  end

  // internal divider, only alive while the main supply feeds the fast clock
  always_ff @(posedge clk) begin
    if (reset || !mainGood) begin
      divCnt_reg <= 16'h0000;
    end else if (divCnt_reg == 16'(DIV - 1)) begin
      divCnt_reg <= 16'h0000;
    end else begin
      divCnt_reg <= divCnt_reg + 16'h0001;
    end
  end

  assign intTick = mainGood && (divCnt_reg == 16'(DIV - 1));

  // source select; without an external clock the tick stops in standby
  always_comb begin
    if (extAbsent) begin
      slowTick = intTick;
    end else begin
      slowTick = slowClkSync && !slowClkDly_reg;
    end
  end

endmodule

//--- rtl/swp_wake_latch.sv
// sticky wake status flags, one per source
// assumes event and clear inputs come from logic on the same clock
`timescale 1ns/1ps
module swp_wake_latch #(
  parameter int unsigned N = 15
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // events and software clears
  input  wire logic [N-1:0] event_,
  input  wire logic [N-1:0] clear,
  // flags
  output logic      [N-1:0] status
);

  // ---------------------------------------------------------------
  // per-source flag; a set in the clearing cycle is kept
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (reset) begin
          status[i] <= 1'b0;
        end else if (event_[i]) begin
          status[i] <= 1'b1;
        end else if (clear[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

//--- sim/swp_standby_ctrl_asserts.sv
// checker for the standby wake and power control block
// assumes it is bound to swp_standby_ctrl and sees only its ports
`timescale 1ns/1ps
module swp_standby_ctrl_asserts import swp_pkg::*; (
  // clock and resets
  input wire logic         clk,
  input wire logic         reset,
  input wire logic         mainPorReset,
  input wire logic         busReset,
  // watched pins
  input wire logic         mainSupplyGood,
  input wire logic         secondPortTx,
  input wire swp_reg_req_s regReq,
  input wire logic         regAck,
  input wire logic         wakeEventOutO,
  input wire logic         wakeEventOutOe,
  input wire logic [1:0]   fanCtlO,
  input wire logic [1:0]   fanCtlOe,
  input wire logic         irTransmitOut,
  input wire logic         gpio53TxAlt,
  input wire logic         irHalfDuplexTimeoutEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  a_wake_pulls_low: assert property (wakeEventOutO == 1'b0)
    else $error("wake pad drives high");
  a_ack_has_cause: assert property (regAck |-> $past(regReq.rd || regReq.wr))
    else $error("ack without request");
  a_ack_next_cycle: assert property (mainSupplyGood [*4] ##0 (regReq.rd || regReq.wr) |=> regAck)
    else $error("request not answered");
  a_refuse_no_good: assert property ((!mainSupplyGood) [*5] |-> !regAck)
    else $error("access decoded without main supply");
  a_ir_low_nogood: assert property ((!mainSupplyGood) [*4] |-> !irTransmitOut && !gpio53TxAlt)
    else $error("ir pad high without main supply");
  a_hdto_off_nogood: assert property ((!mainSupplyGood) [*4] |-> !irHalfDuplexTimeoutEn)
    else $error("half duplex timeout enabled without main supply");
  a_fan_reset_low: assert property ((mainPorReset || busReset) |=> fanCtlOe == 2'h3 && fanCtlO == 2'h0)
    else $error("fan pads not low output after reset");
  a_ir_reset_low: assert property ((mainPorReset || busReset) |=> !irTransmitOut && !gpio53TxAlt)
    else $error("ir pads not low after reset");
  a_ir_follows_tx: assert property ((irTransmitOut || gpio53TxAlt) |-> $past(secondPortTx))
    else $error("ir pad high while transmit was low");
  // main scenarios reached
  c_ack: cover property (regAck);
  c_wake: cover property ($rose(wakeEventOutOe));
  c_ir: cover property (irTransmitOut);
endmodule
bind swp_standby_ctrl swp_standby_ctrl_asserts uChk (.clk(clk), .reset(reset), .mainPorReset(mainPorReset),
  .busReset(busReset), .mainSupplyGood(mainSupplyGood), .secondPortTx(secondPortTx), .regReq(regReq),
  .regAck(regAck), .wakeEventOutO(wakeEventOutO), .wakeEventOutOe(wakeEventOutOe), .fanCtlO(fanCtlO),
  .fanCtlOe(fanCtlOe), .irTransmitOut(irTransmitOut), .gpio53TxAlt(gpio53TxAlt),
  .irHalfDuplexTimeoutEn(irHalfDuplexTimeoutEn));

//--- sim/swp_chipset_model.sv
// chipset side of the wake line: board pull-up and the resolved level
// assumes the enable is high while the block pulls the pad
`timescale 1ns/1ps
module swp_chipset_model (
  // wake pad from the block
  input  wire logic wakeO,
  input  wire logic wakeOe,
  // resolved line, low means wake requested
  output logic      pmeLine
);
  // released pad floats to the pull-up, never the last value
  assign pmeLine = wakeOe ? wakeO : 1'b1;
endmodule

//--- sim/swp_standby_ctrl_tb.sv
// bench for the standby wake and power control block
// assumes the chipset model resolves the open-drain wake pad
`timescale 1ns/1ps
module swp_standby_ctrl_tb import swp_pkg::*; ();
  logic clk, reset, mpr, brst, good, slow, alt, tx, ack, wo, woe, g43o, g43oe;
  logic irt, g53, hdto, indicator_one, indicator_two, a;
  logic [3:0] ln;
  logic [1:0] tach, fo, foe;
  logic [7:0] gin, rd, r;
  logic [15:0] st;
  swp_reg_req_s rq;
  wire pme;
  int mismatches, check_count, ticks, g, s;
  swp_standby_ctrl uut (.clk(clk), .reset(reset), .mainPorReset(mpr), .busReset(brst),
    .mainSupplyGood(good), .slowClockIn(slow), .ringIndicateOneN(ln[0]), .ringIndicateTwoN(ln[1]),
    .kbdSerialData(ln[2]), .mouseSerialData(ln[3]), .fanTach(tach), .gpioWakeIn(gin), .regReq(rq),
    .regRdData(rd), .regAck(ack), .wakeEventOutO(wo), .wakeEventOutOe(woe), .gpio43AltIn(alt),
    .gpio43O(g43o), .gpio43Oe(g43oe), .fanCtlO(fo), .fanCtlOe(foe), .secondPortTx(tx),
    .irTransmitOut(irt), .gpio53TxAlt(g53), .irHalfDuplexTimeoutEn(hdto), .indicatorOne(indicator_one),
    .indicatorTwo(indicator_two));
  swp_chipset_model host (.wakeO(wo), .wakeOe(woe), .pmeLine(pme));
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task results;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] sv, input logic [15:0] ev);
    check_count++;
    if (sv !== ev) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, sv, ev);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // n external slow clock periods, each long enough for the pin synchroniser
  task slowTicks(input int n);
    repeat (n) begin
      slow = 1;
      wt(3);
      slow = 0;
      wt(3);
    end
  endtask
  // one request cycle, answer sampled once the ack edge has landed
  task acc(input logic [7:0] ad, input logic w, input logic [7:0] d);
    @(negedge clk) rq = '{ad, w, !w, d};
    @(negedge clk) r = rd;
    a = ack;
    rq = '0;
  endtask
  // two flops of sync inside, so allow settling after a supply change
  task setGood(input logic v);
    good = v;
    wt(5);
  endtask
  function automatic logic [15:0] expSts(input int src);
    return 16'h1 << src;
  endfunction
  // clock and hang guard
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    ticks++;
    if (ticks == 5000) begin
      mismatches++;
      results;
    end
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    {mpr, brst, slow, tach, gin, rq, ticks, mismatches, check_count} = '0;
    {reset, good, alt, tx, ln} = 8'hff;
    void'($urandom(32'hc655c8f9));
    wt(16);
    reset = 0;
    wt(4);
    chk({foe, fo, irt, g53, indicator_one, indicator_two, woe}, 9'h180);
    acc(OFS_WAKE_STS_LO, 1, 8'hff);
    acc(OFS_WAKE_STS_HI, 1, 8'hff);
    // rings, keyboard, mouse and one wake GPIO; last pass has its enable off
    for (int k = 0; k < 5; k++) begin
      g = $urandom % 8;
      s = (k < 4) ? k : SRC_GPIO + g;
      acc(OFS_WAKE_EN_LO, 1, (k < 4) ? 8'hff : 8'h00);
      acc(OFS_WAKE_EN_HI, 1, (k < 4) ? 8'h7f : 8'h00);
      setGood(0);
      acc(OFS_CLOCK_DETECT, 1, 8'h01);
      chk(a, 0);
      if (k < 4) ln[k] = 0;
      else gin[g] = ~gin[g];
      wt(4);
      ln = 4'hf;
      wt(4);
      chk(pme, k == 4);
      setGood(1);
      chk(pme, k == 4);
      acc(OFS_WAKE_STS_LO, 0, 8'h00);
      st[7:0] = r;
      acc(OFS_WAKE_STS_HI, 0, 8'h00);
      chk({r, st[7:0]}, expSts(s));
      acc(OFS_WAKE_STS_LO, 1, st[7:0]);
      acc(OFS_WAKE_STS_HI, 1, r);
      wt(3);
      chk(pme, 1);
    end
    acc(OFS_CLOCK_DETECT, 0, 8'h00);
    chk(r, 8'h00);
    acc(OFS_CLOCK_DETECT, 1, 8'h01);
    acc(OFS_CLOCK_DETECT, 0, 8'h00);
    chk(r, 8'h01);
    acc(OFS_CLOCK_DETECT, 1, 8'h00);
    acc(8'h55, 0, 8'h00);
    chk({a, r}, 9'h100);
    // tach and key wakes on external slow clock edges
    acc(OFS_WAKE_EN_LO, 1, 8'h20);
    tach = 2'b01;
    slowTicks(1);
    chk(pme, 0);
    acc(OFS_WAKE_EN_LO, 1, 8'h00);
    wt(2);
    chk(pme, 1);
    ln[2] = 0;
    slowTicks(4);
    ln = 4'hf;
    acc(OFS_WAKE_STS_LO, 0, 8'h00);
    chk(r, expSts(SRC_TACH0) | expSts(SRC_KBD) | expSts(SRC_KEY));
    acc(OFS_WAKE_STS_LO, 1, r);
    // ir, led and gpio_43 across a main supply loss
    acc(OFS_IR_CTL, 1, 8'h03);
    acc(OFS_LED_CTL, 1, 8'h0a);
    acc(OFS_GPIO43_CTL, 1, 8'h0b);
    acc(OFS_FAN_CTL, 1, 8'h0c);
    chk({foe, fo, irt, g53, hdto, g43o, g43oe}, 9'h07f);
    tx = 1'($urandom);
    wt(2);
    chk({irt, g53}, {2{tx}});
    setGood(0);
    chk({irt, g53, hdto, indicator_one, indicator_two, g43oe}, 6'h06);
    setGood(1);
    acc(OFS_GPIO43_CTL, 0, 8'h00);
    chk(r, 8'h03);
    brst = 1;
    wt(1);
    brst = 0;
    chk({foe, fo}, 4'hc);
    mpr = 1;
    wt(1);
    mpr = 0;
    wt(2);
    chk({irt, g53}, 2'h0);
    results;
  end
endmodule
